// ### verilog/vspp_pipeline.sv
// Stream converters, linear scaler and duplicator joined in one pipeline.
`timescale 1ns/1ps
`include "vspp_map.svh"
module vspp_pipeline (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic [10:0] row_count,
	input  wire logic [10:0] column_count,
	input  wire logic [15:0] scale_factor,
	input  wire logic [15:0] scale_offset,
	input  wire logic [23:0] s_axis_tdata,
	input  wire logic        s_axis_tvalid,
	output logic             s_axis_tready,
	input  wire logic        s_axis_tlast,
	input  wire logic        s_axis_tuser,
	output logic      [23:0] m0_axis_tdata,
	output logic             m0_axis_tvalid,
	input  wire logic        m0_axis_tready,
	output logic             m0_axis_tlast,
	output logic             m0_axis_tuser,
	output logic      [23:0] m1_axis_tdata,
	output logic             m1_axis_tvalid,
	input  wire logic        m1_axis_tready,
	output logic             m1_axis_tlast,
	output logic             m1_axis_tuser,
	output logic             frame_done
);
	// Sizes are sampled from the ports and must stay still mid-frame.
	// Only clock, reset, stream, size, scale and frame_done ports exist; frame stores live outside.
	// The pipeline has four parts. The input converter turns packets into
	// a raster of exactly the configured size, the scaler works on each
	// byte channel on its own, and the output converter marks lines and
	// frames again from its own counters before the duplicator hands one
	// copy to each consumer.
	// The output registers hold one pixel for both copies together, so a
	// slow consumer on either copy holds back the whole pipeline; this keeps
	// the two copies in step at the cost of some throughput.
	// Sizes above the build-time maximum are clamped rather than refused,
	// because the block has no way to report an error to software.
	vspp_pkg::vspp_in_state_t state_q;
	vspp_pkg::vspp_in_state_t state_d;
	logic [10:0] in_col_q;
	logic [10:0] in_row_q;
	logic [10:0] rows_eff;
	logic [10:0] cols_eff;
	logic        col_end;
	logic        row_end;
	logic        in_fire;
	logic        emit;
	logic        emit_sof;
	logic [23:0] emit_pix;
	logic        take_ok;
	logic [23:0] scaled_pix;
	logic        o_free;
	logic        s_axis_tready_q;
	logic        first_q;
	logic [10:0] out_col_q;
	logic [10:0] out_row_q;
	logic        out_col_end;
	logic        out_row_end;
	logic        out_last;
	logic        out_sof;
	logic        frame_done_q;
	logic        seek_hit;
	logic        pass_st;
	logic        pad_st;
	logic        m0_next_v;
	logic        m1_next_v;
	logic        out_idle_next;
	logic        accept_st;
	logic        drop_st;

	// Runtime size is clamped to the build-time maximum.
	assign rows_eff = (row_count > `VSPP_MAX_DIM) ? `VSPP_MAX_DIM :
		row_count;
	assign cols_eff = (column_count > `VSPP_MAX_DIM) ? `VSPP_MAX_DIM :
		column_count;
	assign col_end = (in_col_q == cols_eff - 11'h001);
	assign row_end = (in_row_q == rows_eff - 11'h001);

	// Output stage can take a pixel when both copies are free or leaving.
	assign o_free = (!m0_axis_tvalid | m0_axis_tready) &
		(!m1_axis_tvalid | m1_axis_tready);
	assign take_ok = o_free;
	assign in_fire = s_axis_tvalid & s_axis_tready_q;

	// Input converter: a pixel reaches the scaler only from the pass, seek
	// or pad states, so every frame handed on is rows times columns.
	// Pass and seek consume a pixel from the slave port and therefore emit
	// only on a real handshake; pad invents its pixel and needs only room
	// in the output stage.
	assign seek_hit = (state_q == vspp_pkg::VSPP_IN_SEEK) & s_axis_tuser;
	assign pass_st = (state_q == vspp_pkg::VSPP_IN_PASS);
	assign pad_st = (state_q == vspp_pkg::VSPP_IN_PAD);
	assign emit = take_ok & ((in_fire & (pass_st | seek_hit)) | pad_st);
	// Padding uses black so that a short line never shows stale data.
	assign emit_pix = pad_st ? 24'h000000 : s_axis_tdata;
	assign emit_sof = (in_row_q == 11'h000) & (in_col_q == 11'h000);

	always_comb begin
		state_d = state_q;
		case (state_q)
		vspp_pkg::VSPP_IN_SEEK: begin
			// Everything before a frame start is thrown away.
			if (emit) begin
				if (col_end & s_axis_tlast)
					state_d = row_end ? vspp_pkg::VSPP_IN_SEEK :
						vspp_pkg::VSPP_IN_PASS;
				else if (col_end)
					state_d = vspp_pkg::VSPP_IN_DROP;
				else if (s_axis_tlast)
					state_d = vspp_pkg::VSPP_IN_PAD;
				else
					state_d = vspp_pkg::VSPP_IN_PASS;
			end
		end
		vspp_pkg::VSPP_IN_PASS: begin
			if (emit & col_end & !s_axis_tlast)
				state_d = vspp_pkg::VSPP_IN_DROP;
			else if (emit & !col_end & s_axis_tlast)
				state_d = vspp_pkg::VSPP_IN_PAD;
			else if (emit & col_end & row_end)
				state_d = vspp_pkg::VSPP_IN_SEEK;
		end
		vspp_pkg::VSPP_IN_PAD: begin
			if (emit & col_end)
				state_d = row_end ? vspp_pkg::VSPP_IN_SEEK :
					vspp_pkg::VSPP_IN_PASS;
		end
		vspp_pkg::VSPP_IN_DROP: begin
			if (in_fire & s_axis_tlast)
				state_d = first_q ? vspp_pkg::VSPP_IN_SEEK :
					vspp_pkg::VSPP_IN_PASS;
		end
		default: state_d = vspp_pkg::VSPP_IN_SEEK;
		endcase
	end

	// Drop state leaving at a frame end goes back to hunting for a start.
	always_ff @(posedge clk) begin
		if (reset)
			first_q <= 1'b0;
		else if (emit)
			first_q <= col_end & row_end;
	end

	// The ready flag is a flip-flop, so outside drop state it may only rise when both copies
	// are sure to be empty on the next cycle; a pixel accepted then always
	// finds room. The price is at best one pixel every other cycle, which
	// spares the slave port a skid buffer.
	assign m0_next_v = emit | (m0_axis_tvalid & !m0_axis_tready);
	assign m1_next_v = emit | (m1_axis_tvalid & !m1_axis_tready);
	assign out_idle_next = !m0_next_v & !m1_next_v;
	assign accept_st = (state_d == vspp_pkg::VSPP_IN_SEEK) |
		(state_d == vspp_pkg::VSPP_IN_PASS);
	assign drop_st = (state_d == vspp_pkg::VSPP_IN_DROP);

	// Tready for the slave port follows the next state so pixels in pad
	// state stall upstream and those in drop state are always absorbed.
	always_ff @(posedge clk) begin
		if (reset)
			s_axis_tready_q <= 1'b0;
		else
			s_axis_tready_q <= drop_st | (accept_st & out_idle_next);
	end
	assign s_axis_tready = s_axis_tready_q;

	always_ff @(posedge clk) begin
		if (reset)
			state_q <= vspp_pkg::VSPP_IN_SEEK;
		else
			state_q <= state_d;
	end

	// Raster position of the next pixel handed downstream.
	always_ff @(posedge clk) begin
		if (reset) begin
			in_col_q <= 11'h000;
			in_row_q <= 11'h000;
		end else if (emit) begin
			in_col_q <= col_end ? 11'h000 : in_col_q + 11'h001;
			if (col_end)
				in_row_q <= row_end ? 11'h000 : in_row_q + 11'h001;
		end
	end

	// Scaler on each of three byte channels, same size in and out.
	genvar ch;
	generate
		for (ch = 0; ch < 3; ch = ch + 1) begin : g_chan
			vspp_chan_scale u_scale (
				.chan_in  (emit_pix[ch*8 +: 8]),
				.factor   (scale_factor),
				.offset   (scale_offset),
				.chan_out (scaled_pix[ch*8 +: 8])
			);
		end
	endgenerate

	// Output converter recounts position from configured size.
	assign out_col_end = (out_col_q == cols_eff - 11'h001);
	assign out_row_end = (out_row_q == rows_eff - 11'h001);
	assign out_last = out_col_end;
	assign out_sof = (out_col_q == 11'h000) & (out_row_q == 11'h000);

	always_ff @(posedge clk) begin
		if (reset) begin
			out_col_q <= 11'h000;
			out_row_q <= 11'h000;
		end else if (emit) begin
			out_col_q <= out_col_end ? 11'h000 : out_col_q + 11'h001;
			if (out_col_end)
				out_row_q <= out_row_end ? 11'h000 : out_row_q + 11'h001;
		end
	end

	// Duplicator: each copy holds its pixel until its own consumer takes it.
	always_ff @(posedge clk) begin
		if (reset) begin
			m0_axis_tvalid <= 1'b0;
			m0_axis_tdata  <= 24'h000000;
			m0_axis_tlast  <= 1'b0;
			m0_axis_tuser  <= 1'b0;
		end else if (emit) begin
			m0_axis_tvalid <= 1'b1;
			m0_axis_tdata  <= scaled_pix;
			m0_axis_tlast  <= out_last;
			m0_axis_tuser  <= out_sof;
		end else if (m0_axis_tready) begin
			m0_axis_tvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			m1_axis_tvalid <= 1'b0;
			m1_axis_tdata  <= 24'h000000;
			m1_axis_tlast  <= 1'b0;
			m1_axis_tuser  <= 1'b0;
		end else if (emit) begin
			m1_axis_tvalid <= 1'b1;
			m1_axis_tdata  <= scaled_pix;
			m1_axis_tlast  <= out_last;
			m1_axis_tuser  <= out_sof;
		end else if (m1_axis_tready) begin
			m1_axis_tvalid <= 1'b0;
		end
	end

	// One-cycle pulse when the last pixel of a frame is emitted.
	// It marks the hand-over into the output registers, not the moment a
	// consumer takes the pixel, so it may lead the final transfer.
	always_ff @(posedge clk) begin
		if (reset)
			frame_done_q <= 1'b0;
		else
			frame_done_q <= emit & out_col_end & out_row_end;
	end
	assign frame_done = frame_done_q;

	// Unused in logic; no verification module reads emit_sof either.
	logic unused_sof;
	assign unused_sof = emit_sof;
endmodule

// ### inc/vspp_map.svh
// Constants for the video stream pixel pipeline.
`ifndef VSPP_MAP_SVH
`define VSPP_MAP_SVH
`define VSPP_ROW_COUNT_OFS   8'h14
`define VSPP_COL_COUNT_OFS   8'h1C
`define VSPP_MAX_DIM         11'h7FF
`define VSPP_DIM_W           11
`define VSPP_CHAN_W          8
`define VSPP_PIX_W           24
`define VSPP_FRAC_W          8
`define VSPP_SCALE_ONE       16'h0100
`define VSPP_SCALE_RST       16'h0200
`define VSPP_OFFSET_RST      16'h0000
`define VSPP_USER_SOF_BIT    0
`endif

// ### inc/vspp_pkg.sv
// Types shared by the video stream pixel pipeline.
package vspp_pkg;
	typedef enum logic [1:0] {
		VSPP_IN_SEEK,
		VSPP_IN_PASS,
		VSPP_IN_PAD,
		VSPP_IN_DROP
	} vspp_in_state_t;
	typedef logic [10:0] vspp_dim_t;
	typedef logic [23:0] vspp_pix_t;
endpackage

// ### verilog/vspp_chan_scale.sv
// One channel of the linear pixel scaler.
`timescale 1ns/1ps
`include "vspp_map.svh"
module vspp_chan_scale (
	input  wire logic [7:0]  chan_in,
	input  wire logic [15:0] factor,
	input  wire logic [15:0] offset,
	output logic      [7:0]  chan_out
);
	// Factor is unsigned 8.8, offset signed 8.8; result saturates to 0..255.
	logic        [23:0] product;
	logic signed [25:0] sum;
	assign product = chan_in * factor;
	assign sum = $signed({2'b00, product}) +
		$signed({{10{offset[15]}}, offset});
	assign chan_out = sum[25] ? 8'h00 :
		(|sum[24:16]) ? 8'hFF : sum[15:8];
endmodule

// ### verification/vspp_sink.sv
// Consumer model for both output copies, with an optional stall pattern.
`timescale 1ns/1ps
module vspp_sink (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic stall_en,
	output logic      rdy0,
	output logic      rdy1
);
	logic [1:0] cnt_q;
	always_ff @(posedge clk) begin
		if (reset)
			cnt_q <= 2'h0;
		else
			cnt_q <= cnt_q + 2'h1;
	end
	// rdy0 drops on two cycles in four and rdy1 on one of those, so only copy 1 ever waits for the other.
	assign rdy0 = !stall_en || cnt_q[0];
	assign rdy1 = !stall_en || cnt_q != 2'h2;
endmodule

// ### verification/vspp_pipeline_monitor.sv
// Checker for the output streams of the pipeline.
`timescale 1ns/1ps
module vspp_pipeline_monitor (
	input wire logic        clk,
	input wire logic        reset,
	input wire logic [10:0] row_count,
	input wire logic [10:0] column_count,
	input wire logic        s_axis_tready,
	input wire logic [23:0] m0_axis_tdata,
	input wire logic        m0_axis_tvalid,
	input wire logic        m0_axis_tready,
	input wire logic        m0_axis_tlast,
	input wire logic        m0_axis_tuser,
	input wire logic [23:0] m1_axis_tdata,
	input wire logic        m1_axis_tvalid,
	input wire logic        m1_axis_tready,
	input wire logic        m1_axis_tlast,
	input wire logic        frame_done
);
	logic [10:0] col_q;
	logic [10:0] row_q;
	wire         take = m0_axis_tvalid && m0_axis_tready;
	wire         last_row = row_q == row_count - 11'h001;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	always_ff @(posedge clk) begin
		if (reset) begin
			col_q <= 11'h000;
			row_q <= 11'h000;
		end else if (take) begin
			col_q <= m0_axis_tlast ? 11'h000 : col_q + 11'h001;
			if (m0_axis_tlast)
				row_q <= last_row ? 11'h000 : row_q + 11'h001;
		end
	end
	sequence s_stall0;
		m0_axis_tvalid && !m0_axis_tready;
	endsequence
	sequence s_stall1;
		m1_axis_tvalid && !m1_axis_tready;
	endsequence
	a_copy_match: assert property (m0_axis_tvalid && m1_axis_tvalid |->
		m0_axis_tdata == m1_axis_tdata && m0_axis_tlast == m1_axis_tlast)
		else $error("copies differ");
	a_hold_m0: assert property (s_stall0 |=> m0_axis_tvalid &&
		$stable(m0_axis_tdata) && $stable(m0_axis_tlast))
		else $error("first copy not held");
	a_hold_m1: assert property (s_stall1 |=> m1_axis_tvalid &&
		$stable(m1_axis_tdata) && $stable(m1_axis_tlast))
		else $error("second copy not held");
	a_tlast_col: assert property (m0_axis_tvalid |->
		m0_axis_tlast == (col_q == column_count - 11'h001))
		else $error("line end misplaced");
	a_tuser_sof: assert property (m0_axis_tvalid |->
		m0_axis_tuser == (col_q == 11'h000 && row_q == 11'h000))
		else $error("frame start misplaced");
	a_done_after: assert property (frame_done |->
		m0_axis_tvalid && m0_axis_tlast && last_row)
		else $error("frame done without frame end");
	a_done_pulse: assert property (frame_done &&
		column_count != 11'h001 |=> !frame_done)
		else $error("frame done too long");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=>
		!m0_axis_tvalid && !m1_axis_tvalid && !s_axis_tready && !frame_done)
		else $error("outputs active after reset");
endmodule
bind vspp_pipeline vspp_pipeline_monitor i_vspp_pipeline_monitor (.*);

// ### verification/vspp_pipeline_test.sv
// Self-checking bench for the video stream pixel pipeline.
`timescale 1ns/1ps
module vspp_pipeline_test;
	logic        clk = 1'b0;
	logic        reset = 1'b1;
	logic [10:0] rows = 11'h002;
	logic [10:0] cols = 11'h003;
	logic [15:0] fac = 16'h0200;
	logic [15:0] ofs = 16'h0000;
	logic [23:0] s_data = 24'h000000;
	logic        s_valid = 1'b0;
	logic        s_last = 1'b0;
	logic        s_user = 1'b0;
	logic        stall = 1'b0;
	logic        s_rdy, done, v0, l0, u0, r0, v1, l1, u1, r1;
	logic [23:0] d0, d1;
	logic [25:0] q[$];
	int          error_cnt = 0;
	int          checks = 0;
	int          done_cnt = 0;
	always #50 clk = ~clk;
	vspp_pipeline i_vspp_pipeline (.clk(clk), .reset(reset),
		.row_count(rows), .column_count(cols), .scale_factor(fac),
		.scale_offset(ofs), .s_axis_tdata(s_data), .s_axis_tvalid(s_valid),
		.s_axis_tready(s_rdy), .s_axis_tlast(s_last), .s_axis_tuser(s_user),
		.m0_axis_tdata(d0), .m0_axis_tvalid(v0), .m0_axis_tready(r0),
		.m0_axis_tlast(l0), .m0_axis_tuser(u0), .m1_axis_tdata(d1),
		.m1_axis_tvalid(v1), .m1_axis_tready(r1), .m1_axis_tlast(l1),
		.m1_axis_tuser(u1), .frame_done(done));
	vspp_sink i_vspp_sink (.clk(clk), .reset(reset), .stall_en(stall),
		.rdy0(r0), .rdy1(r1));
	always @(posedge clk) begin
		if (v0 && r0)
			q.push_back({u0, l0, d0});
		if (done)
			done_cnt++;
	end
	task cmp(input string n, input logic [25:0] e, input logic [25:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Valid stays high between pixels; idle() drops it after the last one.
	task send(input logic [23:0] d, input logic l, input logic u);
		s_data = d;
		s_last = l;
		s_user = u;
		s_valid = 1'b1;
		while (s_rdy !== 1'b1) @(negedge clk);
		@(negedge clk);
	endtask
	task idle;
		s_valid = 1'b0;
	endtask
	task pop(input logic [25:0] e);
		int n;
		n = 0;
		while (q.size() == 0 && n < 300) begin
			@(negedge clk);
			n++;
		end
		cmp("pixel", e, (q.size() != 0) ? q.pop_front() : 26'h3FFFFFF);
	endtask
	task done_chk(input int n);
		repeat (3) @(negedge clk);
		cmp("frame_done", 26'(n), 26'(done_cnt));
	endtask
	task t_frame;
		stall = 1'b1;
		for (int i = 0; i < 6; i++)
			send(24'h102030 + 24'(i), i % 3 == 2, i == 0);
		idle();
		for (int i = 0; i < 6; i++)
			pop({i == 0, i % 3 == 2, 24'h204060 + 24'(2 * i)});
		stall = 1'b0;
		done_chk(1);
	endtask
	task t_drop_pad;
		send(24'h7F7F7F, 1'b1, 1'b0);
		send(24'h010203, 1'b0, 1'b1);
		send(24'h040506, 1'b1, 1'b0);
		for (int i = 0; i < 4; i++)
			send(24'h111111 * 24'(i + 1), i == 3, 1'b0);
		idle();
		pop({2'h2, 24'h020406});
		pop({2'h0, 24'h080A0C});
		pop({2'h1, 24'h000000});
		pop({2'h0, 24'h222222});
		pop({2'h0, 24'h444444});
		pop({2'h1, 24'h666666});
		done_chk(2);
	endtask
	task t_offset;
		rows = 11'h001;
		cols = 11'h002;
		fac = 16'h0100;
		ofs = 16'h0500;
		send(24'hFE0010, 1'b0, 1'b1);
		send(24'h000000, 1'b1, 1'b0);
		idle();
		pop({2'h2, 24'hFF0515});
		pop({2'h1, 24'h050505});
		done_chk(3);
	endtask
	task wrap_up;
		if (error_cnt == 0 && checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (10) @(negedge clk);
		reset = 1'b0;
		t_frame();
		t_drop_pad();
		t_offset();
		wrap_up();
	end
	initial begin
		repeat (5000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
endmodule
